// file: src/mcp_pkg.sv
// Shared register map, field layout, reset values and carrier types of the motor PWM block
package mcp_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_TB_CONTROL = 8'h00;
  localparam logic [7:0] OFF_TB_COUNT = 8'h04;
  localparam logic [7:0] OFF_TB_PERIOD = 8'h08;
  localparam logic [7:0] OFF_SPECIAL_CMP = 8'h0C;
  localparam logic [7:0] OFF_PAIR_CONTROL = 8'h10;
  localparam logic [7:0] OFF_UPDATE_CONTROL = 8'h14;
  localparam logic [7:0] OFF_DEADTIME_UNITS = 8'h18;
  localparam logic [7:0] OFF_DEADTIME_SELECT = 8'h1C;
  localparam logic [7:0] OFF_OVERRIDE = 8'h20;
  localparam logic [7:0] OFF_DUTY_BASE = 8'h24;

  // Field positions
  localparam int unsigned DIR_BIT = 15;
  localparam int unsigned TRIG_DIR_BIT = 15;
  localparam int unsigned PAIR_IND_LSB = 8;
  localparam int unsigned HIGH_EN_LSB = 4;
  localparam int unsigned LOW_EN_LSB = 0;
  localparam int unsigned TRIG_POST_LSB = 8;
  localparam int unsigned IMM_UPDATE_BIT = 2;
  localparam int unsigned OVR_SYNC_BIT = 1;
  localparam int unsigned UPD_DISABLE_BIT = 0;
  localparam int unsigned DT_B_PS_LSB = 14;
  localparam int unsigned DT_B_CNT_LSB = 8;
  localparam int unsigned DT_A_PS_LSB = 6;
  localparam int unsigned DT_A_CNT_LSB = 0;
  localparam int unsigned OVR_SEL_LSB = 8;
  localparam int unsigned OVR_OUT_LSB = 0;

  // Writable bits and reset values
  localparam logic [15:0] TB_CONTROL_WMASK = 16'hA0FF;
  localparam logic [15:0] COUNT_WMASK = 16'h7FFF;
  localparam logic [15:0] UPDATE_CONTROL_WMASK = 16'h0F07;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] OVERRIDE_RESET = 16'h3F00;

  // Time base count modes
  localparam logic [1:0] MODE_FREE = 2'b00;
  localparam logic [1:0] MODE_SINGLE = 2'b01;
  localparam logic [1:0] MODE_UPDOWN = 2'b10;
  localparam logic [1:0] MODE_UPDOWN_DBL = 2'b11;

  // Count clock prescale: last prescaler state per code (1, 4, 16, 64 cycles)
  localparam logic [5:0] PRESCALE_LAST_0 = 6'h00;
  localparam logic [5:0] PRESCALE_LAST_1 = 6'h03;
  localparam logic [5:0] PRESCALE_LAST_2 = 6'h0F;
  localparam logic [5:0] PRESCALE_LAST_3 = 6'h3F;

  typedef struct packed {
    logic timebase_on;
    logic unused_14;
    logic idle_halt;
    logic [4:0] unused_12_8;
    logic [3:0] period_event_postscale;
    logic [1:0] input_prescale;
    logic [1:0] timebase_count_mode;
  } mcp_tbcon_type;

  typedef struct packed {
    logic [2:0] high_out;
    logic [2:0] high_oe;
    logic [2:0] low_out;
    logic [2:0] low_oe;
  } mcp_pin_type;

endpackage : mcp_pkg

// file: src/mcp_pwm_timebase.sv
// Motor-control PWM time base, duty generators, dead time, override and APB registers
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Three duty generators, each one high/low pair
// - Complementary pair: low output inverts high output
// - Small instance has a single pair
// - Time base counts only while timebase_on set
// - idle_halt stops counting during processor idle
// - Period events postscaled one to sixteen
// - Count clock prescale 1, 4, 16, 64
// - Four count modes selected by two bits
// - Count register: 15-bit value, direction flag
// - 15-bit period register, top bit reads zero
// - Trigger on count and direction match
// - Trigger postscale one to sixteen matches
// - Per-pair independent or complementary mode bit
// - Per-pin enable; clear releases pin to port
// - Pin enable reset from configuration input
// - Duty updates immediate or time-base synchronized
// - Override applied synchronized or next cycle
// - Update disable blocks period and duty buffer to active transfers
// - Dead-time prescale 1, 2, 4, 8 cycles
// - Six-bit dead-time count per unit
// - Per-pair unit select for each edge
// - 16-bit duty register per generator
// - Override select or manual level per pin
module mcp_pwm_timebase
  import mcp_pkg::*;
#(
  parameter int unsigned NUM_PAIRS = 3
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // System status
  input wire logic cpu_idle,
  input wire logic pin_owner_config,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Output pins
  output mcp_pin_type pins,
  // Events to other peripherals
  output logic special_trigger,
  output logic period_event
);

  localparam logic [2:0] PAIR_MASK = (NUM_PAIRS >= 3) ? 3'b111 :
                                     (NUM_PAIRS == 2) ? 3'b011 : 3'b001;
  localparam logic [5:0] PAIR2_MASK = {{2{PAIR_MASK[2]}}, {2{PAIR_MASK[1]}}, {2{PAIR_MASK[0]}}};
  localparam logic [15:0] PAIR_CONTROL_WMASK = {5'h00, PAIR_MASK, 1'b0, PAIR_MASK, 1'b0, PAIR_MASK};
  localparam logic [15:0] DT_SELECT_WMASK = {10'h000, PAIR2_MASK};
  localparam logic [15:0] OVERRIDE_WMASK = {2'b00, PAIR2_MASK, 2'b00, PAIR2_MASK};
  localparam logic [15:0] OVERRIDE_RESET_M = OVERRIDE_RESET & OVERRIDE_WMASK;

  // Register state
  mcp_tbcon_type tbcon_r;
  logic [14:0] count_r;
  logic dir_r;
  logic [14:0] period_buf_r;
  logic [14:0] period_act_r;
  logic [15:0] secmp_r;
  logic [15:0] pair_ctrl_r;
  logic [15:0] upd_ctrl_r;
  logic [15:0] dt_units_r;
  logic [15:0] dt_select_r;
  logic [15:0] ovr_buf_r;
  logic [15:0] ovr_act_r;
  logic [15:0] duty_buf_r [3];
  logic [15:0] duty_act_r [3];
  logic strap_pending_r;

  // APB state
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] rd_nxt;
  logic hit_nxt;
  logic access;
  logic [2:0] duty_wr;

  // Time base
  logic [5:0] pre_cnt_r;
  logic [5:0] pre_last;
  logic run;
  logic tick;
  logic [14:0] count_nxt;
  logic dir_nxt;
  logic top_evt;
  logic bot_evt;
  logic boundary;
  logic load_buffers;
  logic [3:0] post_cnt_r;
  logic [3:0] trig_cnt_r;
  logic trig_match;
  logic period_event_r;
  logic special_trigger_r;

  // Dead time and pins
  logic [2:0] dta_pre_r;
  logic [2:0] dtb_pre_r;
  logic dta_tick;
  logic dtb_tick;
  logic [2:0] gen_high;
  logic [2:0] gen_low;
  mcp_pin_type pins_r;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pins = pins_r;
  assign special_trigger = special_trigger_r;
  assign period_event = period_event_r;

  // APB: read data is captured in the setup cycle so it leaves a flop,
  // which still leaves the access phase at exactly one cycle, with no wait state.
  assign access = psel & penable & pready_r;

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    hit_nxt = (paddr[1:0] == 2'b00);
    duty_wr = 3'b000;
    unique case (paddr)
      OFF_TB_CONTROL: rd_nxt[15:0] = tbcon_r;
      OFF_TB_COUNT: rd_nxt[15:0] = {dir_r, count_r};
      OFF_TB_PERIOD: rd_nxt[15:0] = {1'b0, period_buf_r};
      OFF_SPECIAL_CMP: rd_nxt[15:0] = secmp_r;
      OFF_PAIR_CONTROL: rd_nxt[15:0] = pair_ctrl_r;
      OFF_UPDATE_CONTROL: rd_nxt[15:0] = upd_ctrl_r;
      OFF_DEADTIME_UNITS: rd_nxt[15:0] = dt_units_r;
      OFF_DEADTIME_SELECT: rd_nxt[15:0] = dt_select_r;
      OFF_OVERRIDE: rd_nxt[15:0] = ovr_buf_r;
      default:
      begin
        hit_nxt = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
          if (PAIR_MASK[k] && paddr == OFF_DUTY_BASE + 8'(4 * k))
          begin
            rd_nxt[15:0] = duty_buf_r[k];
            hit_nxt = 1'b1;
            duty_wr[k] = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else if (ce)
    begin
      if (psel && !penable)
      begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
        pready_r <= 1'b1;
        pslverr_r <= ~hit_nxt;
      end
      else if (access)
      begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
      end
    end
  end

  // Register writes; each takes effect at the access edge of an APB write
  function automatic logic wr_at(input logic [7:0] off);
    return access && pwrite && paddr == off;
  endfunction : wr_at

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      secmp_r <= REG_RESET;
      upd_ctrl_r <= REG_RESET;
      dt_units_r <= REG_RESET;
      dt_select_r <= REG_RESET;
      ovr_buf_r <= OVERRIDE_RESET_M;
      period_buf_r <= 15'h0000;
    end
    else if (ce)
    begin
      if (wr_at(OFF_SPECIAL_CMP))
        secmp_r <= pwdata[15:0];
      if (wr_at(OFF_UPDATE_CONTROL))
        upd_ctrl_r <= pwdata[15:0] & UPDATE_CONTROL_WMASK;
      if (wr_at(OFF_DEADTIME_UNITS))
        dt_units_r <= pwdata[15:0];
      if (wr_at(OFF_DEADTIME_SELECT))
        dt_select_r <= pwdata[15:0] & DT_SELECT_WMASK;
      if (wr_at(OFF_OVERRIDE))
        ovr_buf_r <= pwdata[15:0] & OVERRIDE_WMASK;
      if (wr_at(OFF_TB_PERIOD))
        period_buf_r <= pwdata[14:0];
    end
  end

  // Pin enables come out of reset from the configuration level, caught
  // at the first enabled edge after release since reset may only load constants.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pair_ctrl_r <= REG_RESET;
      strap_pending_r <= 1'b1;
    end
    else if (ce)
    begin
      if (strap_pending_r)
      begin
        strap_pending_r <= 1'b0;
        pair_ctrl_r <= {9'h000, {3{pin_owner_config}}, 1'b0, {3{pin_owner_config}}}
                       & PAIR_CONTROL_WMASK;
      end
      else if (wr_at(OFF_PAIR_CONTROL))
        pair_ctrl_r <= pwdata[15:0] & PAIR_CONTROL_WMASK;
    end
  end

  // Time base count clock
  assign run = tbcon_r.timebase_on & ~(tbcon_r.idle_halt & cpu_idle);

  always_comb
  begin
    unique case (tbcon_r.input_prescale)
      2'b00: pre_last = PRESCALE_LAST_0;
      2'b01: pre_last = PRESCALE_LAST_1;
      2'b10: pre_last = PRESCALE_LAST_2;
      2'b11: pre_last = PRESCALE_LAST_3;
    endcase
  end

  assign tick = run & (pre_cnt_r == pre_last);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt_r <= 6'h00;
    else if (ce)
    begin
      if (!run || tick)
        pre_cnt_r <= 6'h00;
      else
        pre_cnt_r <= pre_cnt_r + 6'h01;
    end
  end

  // Next count and direction
  always_comb
  begin
    count_nxt = count_r;
    dir_nxt = dir_r;
    top_evt = 1'b0;
    bot_evt = 1'b0;
    unique case (tbcon_r.timebase_count_mode)
      MODE_FREE, MODE_SINGLE:
      begin
        dir_nxt = 1'b0;
        if (count_r >= period_act_r)
        begin
          count_nxt = 15'h0000;
          top_evt = 1'b1;
        end
        else
          count_nxt = count_r + 15'h0001;
      end
      MODE_UPDOWN, MODE_UPDOWN_DBL:
      begin
        if (!dir_r && count_r >= period_act_r)
        begin
          top_evt = 1'b1;
          dir_nxt = (period_act_r != 15'h0000);
          count_nxt = (period_act_r != 15'h0000) ? count_r - 15'h0001 : 15'h0000;
        end
        else if (dir_r && count_r == 15'h0000)
        begin
          bot_evt = 1'b1;
          dir_nxt = 1'b0;
          count_nxt = (period_act_r != 15'h0000) ? 15'h0001 : 15'h0000;
        end
        else if (dir_r)
          count_nxt = count_r - 15'h0001;
        else
          count_nxt = count_r + 15'h0001;
      end
    endcase
  end

  // Period boundary: top in edge modes, bottom in up/down, both in double-update mode
  always_comb
  begin
    unique case (tbcon_r.timebase_count_mode)
      MODE_FREE, MODE_SINGLE: boundary = tick & top_evt;
      MODE_UPDOWN: boundary = tick & bot_evt;
      MODE_UPDOWN_DBL: boundary = tick & (top_evt | bot_evt);
    endcase
  end

  // With the time base stopped there is nothing to sync to, so buffers pass straight through
  assign load_buffers = (boundary | ~tbcon_r.timebase_on) & ~upd_ctrl_r[UPD_DISABLE_BIT];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r <= 15'h0000;
      dir_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_at(OFF_TB_COUNT))
        count_r <= pwdata[14:0] & COUNT_WMASK[14:0];
      else if (tick)
      begin
        count_r <= count_nxt;
        dir_r <= dir_nxt;
      end
    end
  end

  // Single pulse mode switches the time base off after one period; a software write wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tbcon_r <= mcp_tbcon_type'(REG_RESET);
    else if (ce)
    begin
      if (wr_at(OFF_TB_CONTROL))
        tbcon_r <= mcp_tbcon_type'(pwdata[15:0] & TB_CONTROL_WMASK);
      else if (tick && top_evt && tbcon_r.timebase_count_mode == MODE_SINGLE)
        tbcon_r.timebase_on <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      period_act_r <= 15'h0000;
    else if (ce && load_buffers)
      period_act_r <= period_buf_r;
  end

  // Duty buffers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int k = 0; k < 3; k++)
      begin
        duty_buf_r[k] <= REG_RESET;
        duty_act_r[k] <= REG_RESET;
      end
    end
    else if (ce)
    begin
      for (int k = 0; k < 3; k++)
      begin
        if (access && pwrite && duty_wr[k])
        begin
          duty_buf_r[k] <= pwdata[15:0];
          if (upd_ctrl_r[IMM_UPDATE_BIT])
            duty_act_r[k] <= pwdata[15:0];
        end
        else if (load_buffers)
          duty_act_r[k] <= duty_buf_r[k];
      end
    end
  end

  // Override copies every cycle unless it waits for the time base boundary
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ovr_act_r <= OVERRIDE_RESET_M;
    else if (ce && (!upd_ctrl_r[OVR_SYNC_BIT] || boundary || !tbcon_r.timebase_on))
      ovr_act_r <= ovr_buf_r;
  end

  // Period event and special event postscalers
  assign trig_match = tick && count_r == secmp_r[14:0]
                      && dir_r == secmp_r[TRIG_DIR_BIT];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      post_cnt_r <= 4'h0;
      period_event_r <= 1'b0;
    end
    else if (ce)
    begin
      period_event_r <= 1'b0;
      if (boundary)
      begin
        if (post_cnt_r >= tbcon_r.period_event_postscale)
        begin
          post_cnt_r <= 4'h0;
          period_event_r <= 1'b1;
        end
        else
          post_cnt_r <= post_cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_cnt_r <= 4'h0;
      special_trigger_r <= 1'b0;
    end
    else if (ce)
    begin
      special_trigger_r <= 1'b0;
      if (trig_match)
      begin
        if (trig_cnt_r >= upd_ctrl_r[TRIG_POST_LSB +: 4])
        begin
          trig_cnt_r <= 4'h0;
          special_trigger_r <= 1'b1;
        end
        else
          trig_cnt_r <= trig_cnt_r + 4'h1;
      end
    end
  end

  // Dead-time unit tick dividers
  assign dta_tick = dta_pre_r >= 3'((4'h1 << dt_units_r[DT_A_PS_LSB +: 2]) - 4'h1);
  assign dtb_tick = dtb_pre_r >= 3'((4'h1 << dt_units_r[DT_B_PS_LSB +: 2]) - 4'h1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dta_pre_r <= 3'h0;
      dtb_pre_r <= 3'h0;
    end
    else if (ce)
    begin
      dta_pre_r <= dta_tick ? 3'h0 : dta_pre_r + 3'h1;
      dtb_pre_r <= dtb_tick ? 3'h0 : dtb_pre_r + 3'h1;
    end
  end

  // Duty generators with dead time; absent pairs stay inactive
  for (genvar g = 0; g < 3; g++)
  begin : gen_pair
    if (g < NUM_PAIRS)
    begin : gen_used
      logic raw_r;
      logic use_b_r;
      logic [5:0] dt_cnt_r;
      logic raw;
      logic sel_b;

      assign raw = duty_act_r[g] > {1'b0, count_r};
      assign sel_b = raw ? dt_select_r[2 * g + 1] : dt_select_r[2 * g];

      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          raw_r <= 1'b0;
          use_b_r <= 1'b0;
          dt_cnt_r <= 6'h00;
        end
        else if (ce)
        begin
          raw_r <= raw;
          if (raw != raw_r && !pair_ctrl_r[PAIR_IND_LSB + g])
          begin
            use_b_r <= sel_b;
            dt_cnt_r <= sel_b ? dt_units_r[DT_B_CNT_LSB +: 6]
                              : dt_units_r[DT_A_CNT_LSB +: 6];
          end
          else if (dt_cnt_r != 6'h00 && (use_b_r ? dtb_tick : dta_tick))
            dt_cnt_r <= dt_cnt_r - 6'h01;
        end
      end

      assign gen_high[g] = raw_r & (dt_cnt_r == 6'h00) | raw_r & pair_ctrl_r[PAIR_IND_LSB + g];
      // Independent pairs drive both pins from the generator; complementary
      // pairs invert the low pin and hold both off through the dead time.
      assign gen_low[g] = pair_ctrl_r[PAIR_IND_LSB + g] ? raw_r
                          : ~raw_r & (dt_cnt_r == 6'h00);
    end
    else
    begin : gen_absent
      assign gen_high[g] = 1'b0;
      assign gen_low[g] = 1'b0;
    end
  end

  // Pin drivers: override, then per-pin enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pins_r <= '0;
    else if (ce)
    begin
      for (int k = 0; k < 3; k++)
      begin
        pins_r.high_oe[k] <= pair_ctrl_r[HIGH_EN_LSB + k];
        pins_r.low_oe[k] <= pair_ctrl_r[LOW_EN_LSB + k];
        pins_r.high_out[k] <= pair_ctrl_r[HIGH_EN_LSB + k]
          & (ovr_act_r[OVR_SEL_LSB + 2 * k + 1] ? gen_high[k]
                                                : ovr_act_r[OVR_OUT_LSB + 2 * k + 1]);
        pins_r.low_out[k] <= pair_ctrl_r[LOW_EN_LSB + k]
          & (ovr_act_r[OVR_SEL_LSB + 2 * k] ? gen_low[k]
                                            : ovr_act_r[OVR_OUT_LSB + 2 * k]);
      end
    end
  end

endmodule : mcp_pwm_timebase

`default_nettype wire

// file: tb/mcp_pwm_timebase_assertions.sv
// Port-level assertion checker for the motor PWM block
`timescale 1ns/1ps
`default_nettype none
module mcp_pwm_timebase_assertions
  import mcp_pkg::*;
#(
  parameter int unsigned NUM_PAIRS = 3
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and events
  input wire mcp_pin_type pins,
  input wire logic special_trigger,
  input wire logic period_event
);
  // Last mapped duty word shrinks with the pair count
  localparam logic [7:0] LAST_OFF = OFF_DUTY_BASE + 8'(4 * (NUM_PAIRS - 1));
  logic setup;
  assign setup = psel && !penable && ce;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_READY_AFTER_SETUP:
    assert property (setup |=> pready) else $error("no pready after setup");
  AST_READY_ONE_CYCLE:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  AST_ERR_WITH_READY:
    assert property (pslverr |-> pready && psel && penable) else $error("stray pslverr");
  AST_ERR_UNALIGNED:
    assert property (setup && paddr[1:0] != 2'b00 |=> pslverr) else $error("unaligned accepted");
  AST_ERR_UNMAPPED:
    assert property (setup && paddr > LAST_OFF |=> pslverr) else $error("unmapped accepted");
  AST_ERR_READS_ZERO:
    assert property (pready && pslverr |-> prdata == 32'h0) else $error("error read not zero");
  AST_UPPER_ZERO:
    assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper half not zero");
  AST_PRDATA_HOLDS:
    assert property (pready |=> $stable(prdata)) else $error("read data moved");
  AST_PIN_RELEASED:
    assert property (((pins.high_out & ~pins.high_oe) | (pins.low_out & ~pins.low_oe)) == 3'b000)
    else $error("released pin driven");
  AST_ABSENT_PAIRS:
    assert property (((pins.high_oe | pins.low_oe) >> NUM_PAIRS) == 3'b000)
    else $error("absent pair enabled");
  COV_ERR: cover property (pready && pslverr);
  COV_TRIG: cover property (special_trigger);
  COV_PERIOD: cover property (period_event);
  COV_LOW_ON: cover property (pins.low_out[0] && pins.low_oe[0]);
endmodule : mcp_pwm_timebase_assertions

bind mcp_pwm_timebase mcp_pwm_timebase_assertions #(.NUM_PAIRS(NUM_PAIRS)) u_assert (
  .clk(clk),
  .rst_n(rst_n),
  .ce(ce),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .pins(pins),
  .special_trigger(special_trigger),
  .period_event(period_event)
);
`default_nettype wire

// file: tb/mcp_gate_model.sv
// Gate driver model of pair one: tallies on-time and overlap
`timescale 1ns/1ps
`default_nettype none
module mcp_gate_model
  import mcp_pkg::*;
(
  // Clock
  input wire logic clk,
  // Gate inputs
  input wire mcp_pin_type pins,
  // Tallies
  output int hi_cnt,
  output int lo_cnt,
  output int both_cnt
);
  // A released pin drives no gate, whatever level the port shows
  logic hi_on;
  logic lo_on;
  assign hi_on = pins.high_oe[0] && pins.high_out[0];
  assign lo_on = pins.low_oe[0] && pins.low_out[0];
  // Tallies start at zero as two-state variables, so one process drives each
  always @(posedge clk)
  begin
    hi_cnt <= hi_cnt + int'(hi_on);
    lo_cnt <= lo_cnt + int'(lo_on);
    both_cnt <= both_cnt + int'(hi_on && lo_on);
  end
endmodule : mcp_gate_model
`default_nettype wire

// file: tb/test_mcp_pwm_timebase.sv
// Self-checking testbench of the motor PWM block
`timescale 1ns/1ps
`default_nettype none
module test_mcp_pwm_timebase;
  import mcp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic cpu_idle = 1'b0;
  logic strap = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, special_trigger, period_event;
  mcp_pin_type pins;
  int hi_cnt, lo_cnt, both_cnt, dh, dl, db;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] q;
  logic e;

  always #12.5 clk = ~clk;

  mcp_pwm_timebase #(.NUM_PAIRS(3)) uut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .cpu_idle(cpu_idle), .pin_owner_config(strap), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .special_trigger(special_trigger),
    .period_event(period_event));
  mcp_gate_model u_gate (.clk(clk), .pins(pins), .hi_cnt(hi_cnt), .lo_cnt(lo_cnt),
    .both_cnt(both_cnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One idle edge after release so the next setup never lands in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog may end this wait; a missing pready then fails the run
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    check(q, {16'h0000, exp});
  endtask : rd

  task automatic ev(input bit s);
    @(posedge clk);
    while ((s ? special_trigger : period_event) !== 1'b1)
      @(posedge clk);
  endtask : ev

  // First gap after a change may straddle old settings, so skip it
  task automatic gap(input bit s, input int exp);
    realtime t0;
    ev(s);
    ev(s);
    t0 = $realtime;
    ev(s);
    check(int'(($realtime - t0) / 25.0), exp);
  endtask : gap

  task automatic meas;
    int h, l, b;
    ev(1'b0);
    ev(1'b0);
    h = hi_cnt;
    l = lo_cnt;
    b = both_cnt;
    repeat (10) @(posedge clk);
    dh = hi_cnt - h;
    dl = lo_cnt - l;
    db = both_cnt - b;
  endtask : meas

  task automatic still(input logic exp);
    logic [31:0] t;
    apb(1'b0, OFF_TB_COUNT, 16'h0000);
    t = q;
    repeat (4) @(posedge clk);
    apb(1'b0, OFF_TB_COUNT, 16'h0000);
    check(32'(q === t), 32'(exp));
  endtask : still

  task automatic t_reset;
    logic [15:0] r [12] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0077, 16'h0, 16'h0, 16'h0,
      16'h3F00, 16'h0, 16'h0, 16'h0};
    for (int i = 0; i < 12; i++)
      rd(8'(4 * i), r[i]);
    check(32'(pins.high_oe), 32'h7);
    $display("reset values done");
  endtask : t_reset

  task automatic t_regs;
    wr(OFF_TB_CONTROL, 16'h20FF);
    rd(OFF_TB_CONTROL, 16'h20FF);
    wr(OFF_TB_CONTROL, 16'h0000);
    wr(OFF_TB_COUNT, 16'hFFFF);
    rd(OFF_TB_COUNT, 16'h7FFF);
    wr(OFF_TB_PERIOD, 16'hFFFF);
    rd(OFF_TB_PERIOD, 16'h7FFF);
    wr(OFF_UPDATE_CONTROL, 16'hFFFF);
    rd(OFF_UPDATE_CONTROL, 16'h0F07);
    wr(OFF_UPDATE_CONTROL, 16'h0000);
    wr(OFF_DUTY_BASE, 16'hFFFF);
    rd(OFF_DUTY_BASE, 16'hFFFF);
    apb(1'b0, 8'h30, 16'h0000);
    check(32'(e), 32'h1);
    apb(1'b1, 8'h02, 16'h8123);
    check(32'(e), 32'h1);
    rd(OFF_TB_CONTROL, 16'h0000);
    wr(OFF_TB_COUNT, 16'h0000);
    $display("register access done");
  endtask : t_regs

  task automatic t_time;
    logic [15:0] c [7] = '{16'h8000, 16'h8010, 16'h80F0, 16'h8004, 16'h8008, 16'h800C,
      16'h8002};
    int g [7] = '{4, 8, 64, 16, 64, 256, 6};
    wr(OFF_TB_PERIOD, 16'h0003);
    for (int i = 0; i < 7; i++)
    begin
      wr(OFF_TB_CONTROL, c[i]);
      gap(1'b0, g[i]);
    end
    wr(OFF_TB_CONTROL, 16'h8001);
    repeat (20) @(posedge clk);
    rd(OFF_TB_CONTROL, 16'h0001);
    $display("time base done");
  endtask : t_time

  task automatic t_dir;
    logic up, dn;
    up = 1'b0;
    dn = 1'b0;
    wr(OFF_TB_PERIOD, 16'd30);
    wr(OFF_TB_CONTROL, 16'h8003);
    repeat (40)
    begin
      apb(1'b0, OFF_TB_COUNT, 16'h0000);
      if (q[15]) dn = 1'b1;
      else up = 1'b1;
      check(32'(q[14:0] <= 15'd30), 32'h1);
    end
    check(32'({up, dn}), 32'h3);
    cpu_idle <= 1'b1;
    wr(OFF_TB_CONTROL, 16'hA000);
    still(1'b1);
    cpu_idle <= 1'b0;
    still(1'b0);
    wr(OFF_TB_CONTROL, 16'h2000);
    still(1'b1);
    $display("direction and halt done");
  endtask : t_dir

  task automatic t_trig;
    wr(OFF_TB_PERIOD, 16'd9);
    wr(OFF_SPECIAL_CMP, 16'h0005);
    wr(OFF_TB_CONTROL, 16'h8000);
    gap(1'b1, 10);
    wr(OFF_UPDATE_CONTROL, 16'h0200);
    gap(1'b1, 30);
    wr(OFF_UPDATE_CONTROL, 16'h0000);
    wr(OFF_TB_CONTROL, 16'h8002);
    wr(OFF_SPECIAL_CMP, 16'h8005);
    gap(1'b1, 18);
    $display("special trigger done");
  endtask : t_trig

  task automatic t_pins;
    wr(OFF_TB_CONTROL, 16'h8000);
    wr(OFF_DUTY_BASE, 16'h0004);
    meas;
    check(dh, 4);
    check(dl, 6);
    check(db, 0);
    wr(OFF_DEADTIME_UNITS, 16'h0002);
    meas;
    check(dh + dl, 6);
    check(db, 0);
    wr(OFF_DEADTIME_SELECT, 16'h0003);
    wr(OFF_DEADTIME_UNITS, 16'h0302);
    meas;
    check(dh + dl, 4);
    wr(OFF_PAIR_CONTROL, 16'h0177);
    meas;
    check(db, 4);
    wr(OFF_PAIR_CONTROL, 16'h0076);
    meas;
    check(dl, 0);
    wr(OFF_PAIR_CONTROL, 16'h0077);
    wr(OFF_DEADTIME_UNITS, 16'h0000);
    wr(OFF_OVERRIDE, 16'h3D02);
    meas;
    check(dh, 10);
    wr(OFF_OVERRIDE, 16'h3F00);
    wr(OFF_UPDATE_CONTROL, 16'h0001);
    wr(OFF_DUTY_BASE, 16'h0008);
    meas;
    check(dh, 4);
    wr(OFF_UPDATE_CONTROL, 16'h0005);
    wr(OFF_DUTY_BASE, 16'h0006);
    meas;
    check(dh, 6);
    $display("pins done");
  endtask : t_pins

  task automatic complete_run;
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    $display("Error %0t: watchdog expired", $time);
    complete_run;
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_regs;
    t_time;
    t_dir;
    t_trig;
    t_pins;
    complete_run;
  end
endmodule : test_mcp_pwm_timebase
`default_nettype wire
